// ---- hdl/mtc_timer_channel.sv ----
// Multimode 16-bit timer channel top level
`timescale 1ns/1ps
`default_nettype none
module mtc_timer_channel
  import mtc_pkg::*;
(
  input  wire logic        clk,               // System clock
  input  wire logic        arst_n,            // Async reset, active low
  input  wire logic        count_tick,        // Internal count source pulse
  input  wire logic [1:0]  mode,              // Operating mode select
  input  wire logic        start,             // Count start flag
  input  wire logic        up_count,          // Event mode: count up
  input  wire logic        free_run,          // Event mode: free-run type
  input  wire logic        ext_trigger_en,    // One-shot/PWM: pin trigger
  input  wire logic        sw_trigger,        // One-shot/PWM: software trigger pulse
  input  wire logic        wr_en,             // Count register write strobe
  input  wire logic [15:0] wr_data,           // Count register write data
  input  wire logic        rd_en,             // Count register read strobe
  input  wire logic        irq_clear,         // Clear interrupt request
  input  wire logic [7:0]  pwm_high,          // PWM high length in ticks, minus one
  input  wire logic        trigger_event_input_pin, // External trigger/event
  output logic [15:0]      rd_data,           // Count register read data
  output logic             irq_request,       // Timer interrupt request
  output logic             pulse_output_pin   // Timer output
);
  logic [15:0] counter;      // Live count
  logic [15:0] reload;       // Reload register
  logic        pin_level;    // Synchronised pin level
  logic        pin_rise;     // Synchronised pin rising edge
  logic [1:0]  mode_q;       // Previous mode
  logic        mode_valid;   // Mode seen since reset
  logic        start_q;      // Previous start flag
  logic        reload_now;   // Reload instant this cycle
  logic        reload_ovf;   // Reload caused by overflow
  logic        stop_os;      // One-shot stopped by software
  logic        stop_pwm;     // PWM stopped by software
  logic        entering;     // Mode change from timer or event, or out of reset, into one-shot or PWM
  logic        trig;         // Trigger this cycle
  logic        trig_pend;    // Trigger waiting for count tick
  logic        retrig;       // Retrigger seen, reload pending
  logic        retrig_dc;    // Extra down count already done
  logic        out_fall;     // Output drop event for request
  logic        os_done;      // One-shot count expiry
  logic [7:0]  pwm_cnt;      // PWM high phase counter
  logic        pwm_to_low;   // PWM high phase ends
  mtc_state_e  state;        // One-shot / PWM phase
  logic        event_tick;   // Event mode count pulse

  // Pin synchroniser and edge detect
  mtc_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (trigger_event_input_pin),
    .level  (pin_level),
    .rise   (pin_rise)
  );

  // Decoded events
  // All pin events come through the synchroniser, so they lag the pin
  // by two or three clocks. Software triggers act in the same cycle.
  // Stop events look at the previous start flag, so a stop is seen
  // exactly once, on the first cycle the flag reads low.
  assign event_tick = pin_rise & start;
  assign trig       = start & (sw_trigger | (ext_trigger_en & pin_rise));
  assign stop_os    = (mode == MTC_ONESHOT) & start_q & ~start & (state == ST_RUN);
  assign stop_pwm   = (mode == MTC_PWM) & start_q & ~start;
  assign entering   = (mode == MTC_ONESHOT || mode == MTC_PWM) &&
                      (!mode_valid || mode_q == MTC_TIMER || mode_q == MTC_EVENT);
  assign os_done    = (mode == MTC_ONESHOT) & (state == ST_RUN) & count_tick & ~retrig &
                      (counter == CNT_ZEROS);
  assign pwm_to_low = (mode == MTC_PWM) & (state == ST_RUN) & count_tick &
                      (pwm_cnt == 8'h00);

  // Reload instant and its cause
  // The reload instant is a single cycle; in timer and event modes a read
  // strobe in that cycle reports a fixed value instead of the count. In
  // free-run event counting there is no reload, the counter simply wraps.
  always_comb begin
    reload_now = 1'b0;
    reload_ovf = 1'b0;
    if (mode == MTC_TIMER) begin
      reload_now = start & count_tick & (counter == CNT_ZEROS);
    end else if (mode == MTC_EVENT) begin
      if (up_count) begin
        reload_now = event_tick & (counter == CNT_ONES) & ~free_run;
        reload_ovf = 1'b1;
      end else begin
        reload_now = event_tick & (counter == CNT_ZEROS) & ~free_run;
      end
    end else if (mode == MTC_ONESHOT) begin
      // Retrigger reloads after its one extra down count, or at once from zero
      reload_now = os_done | stop_os |
                   (retrig & count_tick & (retrig_dc | (counter == CNT_ZEROS)));
    end
  end

  // Mode history for change detection
  // The first cycle after reset counts as a fresh mode selection, so a
  // one-shot or PWM mode held through reset still raises the request.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q     <= MODE_RST;
      mode_valid <= 1'b0;
      start_q    <= 1'b0;
    end else begin
      mode_q     <= mode;
      mode_valid <= 1'b1;
      start_q    <= start;
    end
  end

  // Reload register follows software writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reload <= RELOAD_RST;
    end else if (wr_en) begin
      reload <= wr_data;
    end
  end

  // Retrigger: one more down count, then reload
  // First tick after the trigger still counts down; the next tick
  // reloads. A count already at zero reloads at once instead of
  // wrapping, since its down count would underflow anyway.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      retrig    <= 1'b0;
      retrig_dc <= 1'b0;
    end else if (mode != MTC_ONESHOT || stop_os) begin
      // Leaving one-shot or stopping drops any pending retrigger
      retrig    <= 1'b0;
      retrig_dc <= 1'b0;
    end else if (trig && state == ST_RUN) begin
      // New trigger restarts the sequence
      retrig    <= 1'b1;
      retrig_dc <= 1'b0;
    end else if (count_tick && retrig) begin
      if (retrig_dc || counter == CNT_ZEROS) begin
        // Reload tick ends the retrigger
        retrig    <= 1'b0;
        retrig_dc <= 1'b0;
      end else begin
        // Extra down count taken
        retrig_dc <= 1'b1;
      end
    end
  end

  // Trigger waits for the next count tick
  // This ties the output edge to the count source, so a trigger may
  // wait up to one count-source period before the output rises.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_pend <= 1'b0;
    end else if (!start) begin
      trig_pend <= 1'b0;
    end else if (trig && state != ST_RUN) begin
      trig_pend <= 1'b1;
    end else if (count_tick) begin
      trig_pend <= 1'b0;
    end
  end

  // Phase machine for one-shot and PWM
  // Idle waits for a trigger, run is the high output phase, low is the
  // PWM low phase. Software stop wins over phase changes, except a one-shot stop while idle, which lets a pending trigger start the run.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else if (mode != MTC_ONESHOT && mode != MTC_PWM) begin
      state <= ST_IDLE;
    end else if (stop_os || stop_pwm) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trig_pend && count_tick) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (os_done) begin
            state <= ST_IDLE;
          end else if (pwm_to_low) begin
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          // Low phase counts the reload value, then restarts
          if (count_tick && counter == CNT_ZEROS) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // PWM high phase length counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_cnt <= 8'h00;
    end else if (state != ST_RUN || mode != MTC_PWM) begin
      pwm_cnt <= pwm_high;
    end else if (count_tick && pwm_cnt != 8'h00) begin
      pwm_cnt <= pwm_cnt - 8'h01;
    end
  end

  // Main counter
  // Writes reach the counter only while stopped, or in event mode so a
  // free-run count can be rewritten right after start. Otherwise a
  // write changes the reload register alone.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counter <= RELOAD_RST;
    end else if (wr_en && (!start || mode == MTC_EVENT)) begin
      counter <= wr_data;
    end else if (reload_now) begin
      counter <= reload;
    end else if (mode == MTC_TIMER) begin
      if (start && count_tick) begin
        counter <= counter - 16'h0001;
      end
    end else if (mode == MTC_EVENT) begin
      if (event_tick) begin
        counter <= up_count ? counter + 16'h0001 : counter - 16'h0001;
      end
    end else if (mode == MTC_ONESHOT) begin
      if (state == ST_IDLE) begin
        counter <= reload;
      end else if (count_tick) begin
        counter <= counter - 16'h0001;
      end
    end else begin
      if (state == ST_IDLE || (state == ST_RUN && !pwm_to_low)) begin
        counter <= reload;
      end else if (pwm_to_low) begin
        counter <= reload;
      end else if (count_tick) begin
        counter <= counter - 16'h0001;
      end
    end
  end

  // Read data: live count, fixed value at timer or event reload instant
  // Data is captured on the read strobe and held until the next one,
  // so a slow reader always sees one coherent value.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= CNT_ZEROS;
    end else if (rd_en) begin
      if (reload_now && mode == MTC_TIMER) begin
        rd_data <= CNT_ONES;
      end else if (reload_now && mode == MTC_EVENT) begin
        rd_data <= reload_ovf ? CNT_ZEROS : CNT_ONES;
      end else begin
        rd_data <= counter;
      end
    end
  end

  // Output pin follows the run phase
  // Drops take priority over rises, so a stop in the same cycle as a
  // phase restart leaves the output low.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_output_pin <= 1'b0;
    end else if (stop_os || stop_pwm || os_done || pwm_to_low) begin
      pulse_output_pin <= 1'b0;
    end else if (state == ST_IDLE && trig_pend && count_tick) begin
      pulse_output_pin <= 1'b1;
    end else if (state == ST_LOW && count_tick && counter == CNT_ZEROS) begin
      pulse_output_pin <= 1'b1;
    end
  end

  // Falling output and mode entry raise the request
  assign out_fall = pulse_output_pin & (stop_pwm | os_done | pwm_to_low);

  // Interrupt request flag, set wins over clear
  // Software must clear the spurious request after a mode entry; a
  // clear that meets a new cause in one cycle is ignored.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_request <= 1'b0;
    end else if (entering || stop_os || out_fall || (reload_now && mode != MTC_ONESHOT)) begin
      irq_request <= 1'b1;
    end else if (irq_clear) begin
      irq_request <= 1'b0;
    end
  end

  // Pin level kept for future gating; unused otherwise
  logic unused_level;
  assign unused_level = pin_level;
endmodule // mtc_timer_channel
`default_nettype wire

// ---- hdl/mtc_pkg.sv ----
// Package of constants and types for the multimode timer channel
// Summary of operation
// - Timer mode: live read, reload instant reads ones
// - Event mode reload read: underflow ones, overflow zeros
// - Stopped counter reads back value just written
// - One-shot stop: halt, reload, output low, request
// - One-shot output synchronised to count source
// - Request set on entering one-shot mode
// - One-shot retrigger: one more count, then reload
// - Request set on entering pulse-width mode
// - PWM stop: halt; high output drops, request
// - PWM stop with low output: no request
package mtc_pkg;
  localparam int        CNT_W     = 16;               // Counter width
  localparam logic [15:0] CNT_ONES  = 16'hFFFF;       // All ones
  localparam logic [15:0] CNT_ZEROS = 16'h0000;       // All zeros
  localparam logic [15:0] RELOAD_RST = 16'h0000;      // Reload reset value
  localparam logic [1:0]  MODE_RST  = 2'h0;           // Timer mode after reset
  // Operating modes
  typedef enum logic [1:0] {
    MTC_TIMER = 2'h0,
    MTC_EVENT = 2'h1,
    MTC_ONESHOT = 2'h2,
    MTC_PWM = 2'h3
  } mtc_mode_e;
  // One-shot / PWM phase states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_LOW  = 3'b100
  } mtc_state_e;
endpackage

// ---- hdl/mtc_sync.sv ----
// Two-flop synchroniser with rising-edge pulse output
`timescale 1ns/1ps
`default_nettype none
module mtc_sync
  import mtc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise
);
  logic meta;   // First stage, read only by second
  logic stage2; // Second stage
  logic prev;   // Delayed copy for edge detect

  // Synchroniser chain and edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta   <= 1'b0;
      stage2 <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= din;
      stage2 <= meta;
      prev   <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~prev;
endmodule // mtc_sync
`default_nettype wire

// ---- bench/mtc_monitor.sv ----
// Port checker for the multimode timer channel
`timescale 1ns/1ps
`default_nettype none
module mtc_monitor
  import mtc_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        count_tick,
  input wire logic [1:0]  mode,
  input wire logic        start,
  input wire logic        rd_en,
  input wire logic        irq_clear,
  input wire logic [15:0] rd_data,
  input wire logic        irq_request,
  input wire logic        pulse_output_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Output low and request raised one cycle on
  sequence s_drop;
    ##1 (!pulse_output_pin && irq_request);
  endsequence
  // Output and request stay quiet for two cycles
  sequence s_quiet;
    ##1 (!irq_request && !pulse_output_pin) [*2];
  endsequence
  AST_RD_HOLD: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  AST_MODE_IRQ: assert property (mode[1] && !$past(mode[1]) |=> irq_request)
    else $error("mode entry raised no request");
  AST_IRQ_HOLD: assert property (irq_request && !irq_clear |=> irq_request)
    else $error("request dropped without clear");
  AST_OS_STOP: assert property (mode == 2'h2 && pulse_output_pin && $fell(start) |-> s_drop)
    else $error("one-shot stop wrong");
  AST_PWM_HIGH: assert property (mode == 2'h3 && pulse_output_pin && $fell(start) |-> s_drop)
    else $error("pwm stop with high output wrong");
  AST_PWM_LOW: assert property (mode == 2'h3 && $stable(mode) && !pulse_output_pin && !irq_request
    && !count_tick && $fell(start) |-> s_quiet)
    else $error("pwm stop with low output wrong");
  AST_OUT_TICK: assert property ($rose(pulse_output_pin) |-> $past(count_tick))
    else $error("output rose off the count source");
  AST_STOP_QUIET: assert property (mode[1] && !start && !$past(start) && !pulse_output_pin
    |=> !pulse_output_pin)
    else $error("stopped output rose");
endmodule // mtc_monitor
bind mtc_timer_channel mtc_monitor u_mon (.clk(clk), .arst_n(arst_n), .count_tick(count_tick), .mode(mode),
  .start(start), .rd_en(rd_en), .irq_clear(irq_clear), .rd_data(rd_data), .irq_request(irq_request),
  .pulse_output_pin(pulse_output_pin));
`default_nettype wire

// ---- bench/mtc_trig_src.sv ----
// External trigger and event source model
`timescale 1ns/1ps
`default_nettype none
module mtc_trig_src (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [3:0] width,
  output logic            pin
);
  logic [3:0] left; // High cycles still to go
  initial begin
    pin = 1'b0;
    left = 4'h0;
  end
  // Pulse held for width cycles, then idle low
  always @(posedge clk) begin
    if (fire) left <= width;
    else if (left != 4'h0) left <= left - 4'h1;
    pin <= fire || (left > 4'h1);
  end
endmodule // mtc_trig_src
`default_nettype wire

// ---- bench/test_multimode_timer_channel.sv ----
// Self-checking bench for the multimode timer channel
`timescale 1ns/1ps
`default_nettype none
module test_multimode_timer_channel
  import mtc_pkg::*;
;
  logic clk = 0, arst_n = 0, count_tick = 0, start = 0, up_count = 0, free_run = 0;
  logic ext_en = 0, sw_trigger = 0, wr_en = 0, rd_en = 0, irq_clear = 0, fire = 0;
  logic [1:0] mode = 2'h0;
  logic [15:0] wr_data = 16'h0000, rd_data, n, seen_rl, seen_nx;
  logic [7:0] pwm_high = 8'h04;
  logic pin, irq, pout;
  int bad_count = 0, cmp_count = 0, hits, k, i;
  mtc_timer_channel dut (.clk(clk), .arst_n(arst_n), .count_tick(count_tick), .mode(mode), .start(start),
    .up_count(up_count), .free_run(free_run), .ext_trigger_en(ext_en), .sw_trigger(sw_trigger),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .irq_clear(irq_clear), .pwm_high(pwm_high),
    .trigger_event_input_pin(pin), .rd_data(rd_data), .irq_request(irq), .pulse_output_pin(pout));
  mtc_trig_src u_src (.clk(clk), .fire(fire), .width(4'h2), .pin(pin));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe selectors
  localparam int TICK = 0, FIRE = 1, WR = 2, RD = 3, CLR = 4, SWT = 5;
  // One-cycle pulse on the selected strobe, high then back low
  task automatic strobe(input int sel);
    repeat (2) begin
      @(posedge clk);
      case (sel)
        TICK: count_tick <= !count_tick;
        FIRE: fire <= !fire;
        WR: wr_en <= !wr_en;
        RD: rd_en <= !rd_en;
        CLR: irq_clear <= !irq_clear;
        default: sw_trigger <= !sw_trigger;
      endcase
    end
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  // One count pulse, tick or pin event, then watch for the reload
  task automatic step(input logic ev);
    if (ev) strobe(FIRE);
    else strobe(TICK);
    repeat (6) begin
      @(negedge clk);
      if (irq === 1'b1 && hits == 0) seen_rl = rd_data;
      if (irq === 1'b1) hits++;
      if (hits == 2) seen_nx = rd_data;
    end
  endtask
  task automatic wr(input logic [15:0] v);
    @(posedge clk) wr_data <= v;
    strobe(WR);
  endtask
  task automatic rd();
    strobe(RD);
    @(negedge clk);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hd6af_dc38));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // Timer down, event down, event up: reload read and length
    for (i = 0; i < 3; i++) begin
      k = $urandom % 4;
      @(posedge clk) mode <= (i == 0) ? 2'h0 : 2'h1;
      up_count <= (i == 2);
      free_run <= 1'b0;
      n = (i == 2) ? 16'hFFFF - 16'(k) : 16'h0003 + 16'(k);
      wr(n);
      rd();
      chk(rd_data, n);
      strobe(CLR);
      @(posedge clk) start <= 1'b1;
      rd_en <= 1'b1;
      hits = 0;
      k = 0;
      while (hits == 0 && k < 20) begin
        k++;
        step(i != 0);
      end
      chk(16'(k), (i == 2) ? 16'hFFFF - n + 16'h0001 : n + 16'h0001);
      chk(seen_rl, (i == 2) ? CNT_ZEROS : CNT_ONES);
      chk(seen_nx, n);
      @(posedge clk) start <= 1'b0;
      rd_en <= 1'b0;
    end
    // Free-run count, rewrite after start, reset once stopped
    @(posedge clk) free_run <= 1'b1;
    start <= 1'b1;
    wr(CNT_ZEROS);
    step(1'b1);
    @(posedge clk) start <= 1'b0;
    mode <= 2'h0;
    @(posedge clk) arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    free_run <= 1'b0;
    rd();
    chk(rd_data, CNT_ZEROS);
    chk(irq, 1'b0);
    // One-shot entry, start, stop mid-count
    @(posedge clk) mode <= 2'h2;
    settle();
    chk(irq, 1'b1);
    strobe(CLR);
    n = 16'h0004 + 16'($urandom % 4);
    wr(n);
    @(posedge clk) start <= 1'b1;
    strobe(SWT);
    step(1'b0);
    chk(pout, 1'b1);
    step(1'b0);
    @(posedge clk) start <= 1'b0;
    settle();
    chk(pout, 1'b0);
    chk(irq, 1'b1);
    rd();
    chk(rd_data, n);
    // Retrigger from the pin: one down count, reload, then n ticks to zero
    strobe(CLR);
    @(posedge clk) start <= 1'b1;
    ext_en <= 1'b1;
    strobe(SWT);
    repeat (2) step(1'b0);
    strobe(FIRE);
    repeat (4) @(posedge clk);
    repeat (n) step(1'b0);
    chk(pout, 1'b1);
    repeat (2) step(1'b0);
    chk(pout, 1'b1);
    step(1'b0);
    chk(pout, 1'b0);
    chk(irq, 1'b1);
    @(posedge clk) start <= 1'b0;
    ext_en <= 1'b0;
    // Pulse-width entry from timer mode, stop high then stop low
    @(posedge clk) mode <= 2'h0;
    @(posedge clk) mode <= 2'h3;
    pwm_high <= 8'h04 + 8'($urandom % 4);
    settle();
    chk(irq, 1'b1);
    strobe(CLR);
    @(posedge clk) start <= 1'b1;
    strobe(SWT);
    repeat (3) if (pout !== 1'b1) step(1'b0);
    chk(pout, 1'b1);
    @(posedge clk) start <= 1'b0;
    settle();
    chk(pout, 1'b0);
    chk(irq, 1'b1);
    strobe(CLR);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    chk(pout, 1'b0);
    print_verdict();
  end
endmodule // test_multimode_timer_channel
`default_nettype wire
